// ### mad_pkg.sv
package mad_pkg;

    // register byte offsets
    localparam logic [7:0] MAD_CFG_OFF = 8'h00;
    localparam logic [7:0] MAD_STAT_OFF = 8'h04;

    // attribute configuration register fields
    localparam int MAD_CFG_B_POS = 0;
    localparam int MAD_CFG_C_POS = 1;
    localparam int MAD_CFG_S_POS = 2;
    localparam int MAD_CFG_TEX_LSB = 3;
    localparam int MAD_CFG_WIDTH = 6;
    localparam logic [5:0] MAD_CFG_RESET = 6'h00;

    // decode status register fields
    localparam int MAD_ST_TYPE_LSB = 0;
    localparam int MAD_ST_SHARE_POS = 2;
    localparam int MAD_ST_INNER_LSB = 3;
    localparam int MAD_ST_OUTER_LSB = 5;
    localparam int MAD_ST_RSVD_POS = 7;
    localparam int MAD_ST_IMPL_POS = 8;

    // axi response codes
    localparam logic [1:0] MAD_RESP_OKAY = 2'h0;
    localparam logic [1:0] MAD_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MAD_MEM_STRONG = 2'b00,
        MAD_MEM_DEVICE = 2'b01,
        MAD_MEM_NORMAL = 2'b10,
        MAD_MEM_NONE = 2'b11
    } mad_mem_type_t;

    typedef enum logic [1:0] {
        MAD_POL_NC = 2'b00,
        MAD_POL_WB_RWA = 2'b01,
        MAD_POL_WT_NWA = 2'b10,
        MAD_POL_WB_NWA = 2'b11
    } mad_policy_t;

endpackage

// ### mad_attr_decode.sv
`timescale 1ns/1ps
module mad_attr_decode
    import mad_pkg::*;
(
    input wire logic [2:0] i_type_extension_field,
    input wire logic i_cacheable,
    input wire logic i_bufferable,
    input wire logic i_shareable,
    output mad_mem_type_t o_mem_type,
    output logic o_shareable,
    output mad_policy_t o_inner_policy_code,
    output mad_policy_t o_outer_policy_code,
    output logic o_reserved,
    output logic o_impl_defined
);

    // pure table lookup; anything not normal memory ignores the shareable bit
    always_comb begin
        o_mem_type = MAD_MEM_NONE;
        o_shareable = 1'b0;
        o_inner_policy_code = MAD_POL_NC;
        o_outer_policy_code = MAD_POL_NC;
        o_reserved = 1'b0;
        o_impl_defined = 1'b0;
        if (i_type_extension_field[2]) begin
            o_mem_type = MAD_MEM_NORMAL;
            o_outer_policy_code = mad_policy_t'(i_type_extension_field[1:0]);
            o_inner_policy_code = mad_policy_t'({i_cacheable, i_bufferable});
            o_shareable = i_shareable;
        end else begin
            unique case ({i_type_extension_field[1:0], i_cacheable, i_bufferable})
                4'b0000: begin
                    o_mem_type = MAD_MEM_STRONG;
                    o_shareable = 1'b1;
                end
                4'b0001: begin
                    o_mem_type = MAD_MEM_DEVICE;
                    o_shareable = 1'b1;
                end
                4'b0010: begin
                    o_mem_type = MAD_MEM_NORMAL;
                    o_inner_policy_code = MAD_POL_WT_NWA;
                    o_outer_policy_code = MAD_POL_WT_NWA;
                    o_shareable = i_shareable;
                end
                4'b0011: begin
                    o_mem_type = MAD_MEM_NORMAL;
                    o_inner_policy_code = MAD_POL_WB_NWA;
                    o_outer_policy_code = MAD_POL_WB_NWA;
                    o_shareable = i_shareable;
                end
                4'b0100: begin
                    o_mem_type = MAD_MEM_NORMAL;
                    o_shareable = i_shareable;
                end
                4'b0110: begin
                    o_impl_defined = 1'b1;
                end
                4'b0111: begin
                    o_mem_type = MAD_MEM_NORMAL;
                    o_inner_policy_code = MAD_POL_WB_RWA;
                    o_outer_policy_code = MAD_POL_WB_RWA;
                    o_shareable = i_shareable;
                end
                4'b1000: begin
                    o_mem_type = MAD_MEM_DEVICE;
                end
                default: begin
                    o_reserved = 1'b1;
                end
            endcase
        end
    end

endmodule

// ### mad_top.sv
`timescale 1ns/1ps
module mad_top
    import mad_pkg::*;
#(
    parameter int AW = 8
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [AW-1:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [AW-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output mad_mem_type_t o_mem_type,
    output logic o_shareable,
    output mad_policy_t o_inner_policy_code,
    output mad_policy_t o_outer_policy_code,
    output logic o_reserved,
    output logic o_impl_defined
);

    logic [MAD_CFG_WIDTH-1:0] cfg_ff;
    logic [AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic nxt_aw_hold;
    logic nxt_w_hold;
    logic nxt_bvalid;
    logic nxt_rvalid;
    logic do_write;
    logic ar_take;
    mad_mem_type_t dec_type;
    logic dec_share;
    mad_policy_t dec_inner;
    mad_policy_t dec_outer;
    logic dec_rsvd;
    logic dec_impl;
    logic [31:0] status_word;

    // word-aligned address match, used by both channels
    function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [7:0] off);
        logic [AW-1:0] off_w;
        off_w = AW'(off);
        reg_hit = (addr[AW-1:2] == off_w[AW-1:2]);
    endfunction

    // the decoder sees the stored attribute bits
    mad_attr_decode u_decode (
        .i_type_extension_field(cfg_ff[MAD_CFG_TEX_LSB +: 3]),
        .i_cacheable(cfg_ff[MAD_CFG_C_POS]),
        .i_bufferable(cfg_ff[MAD_CFG_B_POS]),
        .i_shareable(cfg_ff[MAD_CFG_S_POS]),
        .o_mem_type(dec_type),
        .o_shareable(dec_share),
        .o_inner_policy_code(dec_inner),
        .o_outer_policy_code(dec_outer),
        .o_reserved(dec_rsvd),
        .o_impl_defined(dec_impl)
    );

    // write and read channel bookkeeping; address and data may arrive in either order
    always_comb begin
        do_write = aw_hold_ff & w_hold_ff & ~o_axi_bvalid;
        nxt_aw_hold = do_write ? 1'b0 : (aw_hold_ff | (i_axi_awvalid & o_axi_awready));
        nxt_w_hold = do_write ? 1'b0 : (w_hold_ff | (i_axi_wvalid & o_axi_wready));
        nxt_bvalid = do_write | (o_axi_bvalid & ~i_axi_bready);
        ar_take = i_axi_arvalid & o_axi_arready;
        nxt_rvalid = ar_take | (o_axi_rvalid & ~i_axi_rready);
    end

    // status word mirrors the registered decode outputs
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[MAD_ST_TYPE_LSB +: 2] = o_mem_type;
        status_word[MAD_ST_SHARE_POS] = o_shareable;
        status_word[MAD_ST_INNER_LSB +: 2] = o_inner_policy_code;
        status_word[MAD_ST_OUTER_LSB +: 2] = o_outer_policy_code;
        status_word[MAD_ST_RSVD_POS] = o_reserved;
        status_word[MAD_ST_IMPL_POS] = o_impl_defined;
    end

    // write address and data capture; readies drop while a response is owed
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            o_axi_awready <= 1'b0;
            o_axi_wready <= 1'b0;
        end else begin
            if (i_axi_awvalid && o_axi_awready) begin
                awaddr_ff <= i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                wdata_ff <= i_axi_wdata;
                wstrb_ff <= i_axi_wstrb;
            end
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            o_axi_awready <= ~nxt_aw_hold & ~nxt_bvalid;
            o_axi_wready <= ~nxt_w_hold & ~nxt_bvalid;
        end
    end

    // configuration register and write response
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_ff <= MAD_CFG_RESET;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp <= MAD_RESP_OKAY;
        end else begin
            o_axi_bvalid <= nxt_bvalid;
            if (do_write) begin
                if (reg_hit(awaddr_ff, MAD_CFG_OFF)) begin
                    o_axi_bresp <= MAD_RESP_OKAY;
                    if (wstrb_ff[0]) begin
                        cfg_ff <= wdata_ff[MAD_CFG_WIDTH-1:0];
                    end
                end else if (reg_hit(awaddr_ff, MAD_STAT_OFF)) begin
                    o_axi_bresp <= MAD_RESP_OKAY; // read-only, write dropped
                end else begin
                    o_axi_bresp <= MAD_RESP_SLVERR;
                end
            end
        end
    end

    // read channel: one read in flight, answered the cycle after it is taken
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid <= 1'b0;
            o_axi_rdata <= 32'h0000_0000;
            o_axi_rresp <= MAD_RESP_OKAY;
        end else begin
            o_axi_rvalid <= nxt_rvalid;
            o_axi_arready <= ~nxt_rvalid;
            if (ar_take) begin
                if (reg_hit(i_axi_araddr, MAD_CFG_OFF)) begin
                    o_axi_rdata <= 32'(cfg_ff);
                    o_axi_rresp <= MAD_RESP_OKAY;
                end else if (reg_hit(i_axi_araddr, MAD_STAT_OFF)) begin
                    o_axi_rdata <= status_word;
                    o_axi_rresp <= MAD_RESP_OKAY;
                end else begin
                    o_axi_rdata <= 32'h0000_0000;
                    o_axi_rresp <= MAD_RESP_SLVERR;
                end
            end
        end
    end

    // attribute outputs registered so the fabric sees clean timing
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_mem_type <= MAD_MEM_STRONG;
            o_shareable <= 1'b1;
            o_inner_policy_code <= MAD_POL_NC;
            o_outer_policy_code <= MAD_POL_NC;
            o_reserved <= 1'b0;
            o_impl_defined <= 1'b0;
        end else begin
            o_mem_type <= dec_type;
            o_shareable <= dec_share;
            o_inner_policy_code <= dec_inner;
            o_outer_policy_code <= dec_outer;
            o_reserved <= dec_rsvd;
            o_impl_defined <= dec_impl;
        end
    end

    // checks: outputs follow the stored attributes one cycle later
    wire [2:0] chk_tex = cfg_ff[MAD_CFG_TEX_LSB +: 3];
    wire [1:0] chk_cb = {cfg_ff[MAD_CFG_C_POS], cfg_ff[MAD_CFG_B_POS]};
    wire chk_s = cfg_ff[MAD_CFG_S_POS];

    sequence s_cfg_write;
        do_write && reg_hit(awaddr_ff, MAD_CFG_OFF) && wstrb_ff[0];
    endsequence

    a_cfg_write_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_cfg_write ##1 (wdata_ff[5:3] == 3'b000 && wdata_ff[1:0] == 2'b11)
        |=> o_mem_type == MAD_MEM_NORMAL && o_inner_policy_code == MAD_POL_WB_NWA)
        else $error("configured attributes not reflected on outputs");
    a_wt_normal: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b000 && chk_cb == 2'b10) |=> (o_mem_type == MAD_MEM_NORMAL
        && o_outer_policy_code == MAD_POL_WT_NWA && o_shareable == $past(chk_s)))
        else $error("write-through normal decode wrong");
    a_wb_noalloc: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b000 && chk_cb == 2'b11) |=> (o_inner_policy_code == MAD_POL_WB_NWA
        && o_outer_policy_code == MAD_POL_WB_NWA && o_shareable == $past(chk_s)))
        else $error("write-back no-allocate decode wrong");
    a_noncache_norm: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b001 && chk_cb == 2'b00) |=> (o_mem_type == MAD_MEM_NORMAL
        && o_inner_policy_code == MAD_POL_NC && o_shareable == $past(chk_s)))
        else $error("non-cacheable normal decode wrong");
    a_wb_alloc: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b001 && chk_cb == 2'b11) |=> (o_inner_policy_code == MAD_POL_WB_RWA
        && o_outer_policy_code == MAD_POL_WB_RWA))
        else $error("write-back allocate decode wrong");
    a_cached_split: assert property (@(posedge i_clk) disable iff (!i_resetn)
        chk_tex[2] |=> (o_outer_policy_code == mad_policy_t'($past(chk_tex[1:0]))
        && o_inner_policy_code == mad_policy_t'($past(chk_cb))))
        else $error("cached policy split wrong");
    a_policy_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b110 && chk_cb == 2'b01) |=> (o_outer_policy_code == MAD_POL_WT_NWA
        && o_inner_policy_code == MAD_POL_WB_RWA))
        else $error("policy code mapping wrong");
    a_share_ignored: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_mem_type != MAD_MEM_NORMAL) |-> o_shareable == (o_mem_type != MAD_MEM_NONE
        && !(o_mem_type == MAD_MEM_DEVICE && o_outer_policy_code == MAD_POL_NC
        && !o_reserved && $past(chk_tex, 1) == 3'b010)))
        else $error("shareable bit leaked into non-normal decode");
    a_strong_device: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b000 && !chk_cb[1]) |=> (o_shareable && o_mem_type ==
        ($past(chk_cb[0]) ? MAD_MEM_DEVICE : MAD_MEM_STRONG)))
        else $error("strongly-ordered or device decode wrong");
    a_rsvd_impl: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b010) |=> (o_reserved == ($past(chk_cb) != 2'b00)
        && o_impl_defined == 1'b0))
        else $error("reserved decode wrong");
    // implementation-defined slot carries no usable memory type
    a_impl_defined: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (chk_tex == 3'b001 && chk_cb == 2'b10) |=> (o_impl_defined && !o_reserved
        && o_mem_type == MAD_MEM_NONE && !o_shareable))
        else $error("implementation-defined decode wrong");

endmodule

// ### mad_fabric_model.sv
`timescale 1ns/1ps
// load/store side view of the decoded attributes
// the fabric only listens, so nothing is driven back into the decoder
module mad_fabric_model (
    input wire logic i_clk,
    input wire logic [1:0] i_mem_type,
    input wire logic i_shareable,
    input wire logic [1:0] i_inner_policy_code,
    input wire logic [1:0] i_outer_policy_code,
    input wire logic i_reserved,
    input wire logic i_impl_defined,
    output logic [8:0] o_seen
);
    logic [8:0] seen_ff;

    // attributes sampled one edge late, as a registered bus stage would
    always_ff @(posedge i_clk) begin
        seen_ff <= {i_impl_defined, i_reserved, i_outer_policy_code, i_inner_policy_code,
            i_shareable, i_mem_type};
    end

    assign o_seen = seen_ff;
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
    import mad_pkg::*;
    localparam int AW = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, shareable, rsvd, impl;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    mad_mem_type_t mem_type;
    mad_policy_t inner, outer;
    logic [8:0] dec, seen;
    int miscompares = 0, compares = 0;

    // same bit layout as the decode status word
    assign dec = {impl, rsvd, outer, inner, shareable, mem_type};

    always #2 clk = ~clk;

    mad_top #(.AW(AW)) uut (.i_clk(clk), .i_resetn(resetn), .i_axi_awaddr(awaddr),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
        .i_axi_rready(rready), .o_mem_type(mem_type), .o_shareable(shareable),
        .o_inner_policy_code(inner), .o_outer_policy_code(outer), .o_reserved(rsvd),
        .o_impl_defined(impl));

    mad_fabric_model partner (.i_clk(clk), .i_mem_type(mem_type), .i_shareable(shareable),
        .i_inner_policy_code(inner), .i_outer_policy_code(outer), .i_reserved(rsvd),
        .i_impl_defined(impl), .o_seen(seen));

    // reference decode; reserved and implementation-defined read as type 11, all else 0
    function automatic logic [8:0] exp_dec(input logic [5:0] cfg);
        logic s;
        s = cfg[2];
        exp_dec = {2'b01, 4'h0, 1'b0, 2'b11};
        if (cfg[5]) begin
            exp_dec = {2'b00, cfg[4:3], cfg[1:0], s, 2'b10};
        end else begin
            case ({cfg[4:3], cfg[1:0]})
                4'h0: exp_dec = 9'h004;
                4'h1: exp_dec = 9'h005;
                4'h2: exp_dec = {2'b00, 4'hA, s, 2'b10};
                4'h3: exp_dec = {2'b00, 4'hF, s, 2'b10};
                4'h4: exp_dec = {2'b00, 4'h0, s, 2'b10};
                4'h6: exp_dec = {2'b10, 4'h0, 1'b0, 2'b11};
                4'h7: exp_dec = {2'b00, 4'h5, s, 2'b10};
                4'h8: exp_dec = 9'h001;
                default: exp_dec = {2'b01, 4'h0, 1'b0, 2'b11};
            endcase
        end
    endfunction

    task automatic chk_dec(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // opening edge keeps a release and a new raise out of one time step
    // no cycle count assumed; only the watchdog ends a wait for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        chk_dec(dec, exp_dec(6'h00));
        rd(MAD_CFG_OFF, d, r);
        chk_bus(d, 32'h0);
        chk_bus(32'(r), 32'(MAD_RESP_OKAY));
        $display("test reset done");
    endtask

    // every one of the 64 encodings, so shareable is flipped on each type
    task automatic t_codes();
        logic [31:0] d;
        logic [1:0] r;
        logic [8:0] e;
        for (int i = 0; i < 64; i++) begin
            e = exp_dec(i[5:0]);
            wr(MAD_CFG_OFF, 32'(i), 4'hF, r);
            chk_bus(32'(r), 32'(MAD_RESP_OKAY));
            @(posedge clk);
            #1;
            chk_dec(dec, e);
            rd(MAD_STAT_OFF, d, r);
            chk_bus(d, {23'h0, e});
            chk_dec(seen, e);
        end
        $display("test all encodings done");
    endtask

    task automatic t_refuse();
        logic [31:0] d;
        logic [1:0] r;
        wr(MAD_CFG_OFF, 32'h0000_0023, 4'hF, r);
        wr(MAD_CFG_OFF, 32'h0000_0008, 4'h0, r);
        chk_bus(32'(r), 32'(MAD_RESP_OKAY));
        wr(MAD_STAT_OFF, 32'h0000_0008, 4'hF, r);
        chk_bus(32'(r), 32'(MAD_RESP_OKAY));
        wr(8'h08, 32'h0000_0008, 4'hF, r);
        chk_bus(32'(r), 32'(MAD_RESP_SLVERR));
        rd(8'h0C, d, r);
        chk_bus(d, 32'h0);
        chk_bus(32'(r), 32'(MAD_RESP_SLVERR));
        rd(MAD_CFG_OFF, d, r);
        chk_bus(d, 32'h0000_0023);
        chk_dec(dec, exp_dec(6'h23));
        $display("test refusals done");
    endtask

    // reset in mid-run must drop a cached setting back to strongly-ordered
    task automatic t_mid_reset();
        logic [31:0] d;
        logic [1:0] r;
        wr(MAD_CFG_OFF, 32'h0000_003F, 4'hF, r);
        @(posedge clk);
        #1;
        chk_dec(dec, exp_dec(6'h3F));
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk_dec(dec, exp_dec(6'h00));
        rd(MAD_CFG_OFF, d, r);
        chk_bus(d, 32'h0);
        $display("test mid-run reset done");
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_codes();
        t_refuse();
        t_mid_reset();
        conclude();
    end

    // whole run needs about 550 cycles; about nine times that means a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
